// ### verilog/gbc_pkg.sv
// Constants and types for the instrument bus command decoder.
// Assumes bus pins arrive inverted (active low) and synchronous to clk_in.
package gbc_pkg;
  localparam int       DATA_W     = 8;
  localparam int       FIFO_DEPTH = 16;
  // Command codes, seven bits wide.
  localparam logic [6:0] CMD_GTL = 7'h01;
  localparam logic [6:0] CMD_SDC = 7'h04;
  localparam logic [6:0] CMD_GET = 7'h08;
  localparam logic [6:0] CMD_LLO = 7'h11;
  localparam logic [6:0] CMD_DCL = 7'h14;
  localparam logic [6:0] CMD_SPE = 7'h18;
  localparam logic [6:0] CMD_SPD = 7'h19;
  localparam logic [6:0] CMD_UNL = 7'h3F;
  localparam logic [6:0] CMD_UNT = 7'h5F;
  // Command group held in bits 6:5 of the code.
  localparam logic [1:0] GRP_UCG = 2'h0;
  localparam logic [1:0] GRP_LAG = 2'h1;
  localparam logic [1:0] GRP_TAG = 2'h2;
  localparam logic [1:0] GRP_SCG = 2'h3;
  // Received data word with its end marker.
  typedef struct packed {
    logic [7:0] data;
    logic       eoi;
  } gbc_rx_t;
endpackage

// ### verilog/gbc_decoder.sv
// Bus command decoder with its receive FIFO.
// Assumes all bus inputs are synchronous to clk_in and active low.
`timescale 1ns/1ps
`default_nettype none

module gbc_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  // Clock and reset.
  input  wire logic             clk_in,
  input  wire logic             arst_n_in,
  // Filling side.
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  // Draining side.
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic [WIDTH-1:0]      out_data_out
);
  localparam int CW = $clog2(DEPTH + 1);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [WIDTH-1:0] next_mem [DEPTH];
  logic [CW-1:0]    count;
  logic [CW-1:0]    next_count;
  logic             push;
  logic             pop;
  logic [CW-1:0]    wr_idx;

  // Shift FIFO: the head always sits in slot zero, so it is a flop.
  always_comb begin
    push = in_valid_in && in_ready_out;
    pop  = out_valid_out && out_ready_in;
    wr_idx = count - CW'(pop);
    next_count = count + CW'(push) - CW'(pop);
    for (int i = 0; i < DEPTH; i++) begin
      next_mem[i] = mem[i];
      if (pop && i < DEPTH - 1) begin
        next_mem[i] = mem[i + 1];
      end
      if (push && CW'(i) == wr_idx) begin
        next_mem[i] = in_data_in;
      end
    end
  end

  // Storage and flags; flags are registered so they read honest.
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      count         <= '0;
      in_ready_out  <= 1'b0;
      out_valid_out <= 1'b0;
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= '0;
      end
    end else begin
      count         <= next_count;
      in_ready_out  <= next_count != CW'(DEPTH);
      out_valid_out <= next_count != '0;
      mem           <= next_mem;
    end
  end

  assign out_data_out = mem[0];
endmodule

module gbc_decoder (
  // Clock and reset.
  input  wire logic                clk_in,
  input  wire logic                arst_n_in,
  // Bus lines sensed, active low.
  input  wire logic [7:0]          dio_n_in,
  input  wire logic                atn_n_in,
  input  wire logic                ifc_n_in,
  input  wire logic                ren_n_in,
  input  wire logic                eoi_n_in,
  input  wire logic                dav_n_in,
  // Open-drain bus lines driven by the acceptor and requester.
  output logic                     nrfd_n_out,
  output logic                     nrfd_oe_out,
  output logic                     ndac_n_out,
  output logic                     ndac_oe_out,
  output logic                     srq_n_out,
  output logic                     srq_oe_out,
  // Configuration.
  input  wire logic [4:0]          my_addr_in,
  input  wire logic                trig_unaddr_in,
  input  wire logic                gtl_unlock_in,
  input  wire logic                ren_panel_lock_in,
  input  wire logic                srq_cond_in,
  // Interface state.
  output logic                     remote_out,
  output logic                     lockout_out,
  output logic                     panel_off_out,
  output logic                     listen_out,
  output logic                     talk_out,
  output logic                     spoll_out,
  output logic                     clear_out,
  output logic                     trigger_out,
  // Received data stream.
  output logic                     rx_valid_out,
  input  wire logic                rx_ready_in,
  output gbc_pkg::gbc_rx_t         rx_data_out
);
  typedef enum {AH_IDLE, AH_HOLD} gbc_ah_t;

  // Line decodes an own-address match inside a group.
  function automatic logic addr_hit(input logic [6:0] code,
                                    input logic [1:0] grp,
                                    input logic [4:0] addr);
    addr_hit = code[6:5] == grp && code[4:0] == addr;
  endfunction

  gbc_ah_t          ah;
  gbc_ah_t          next_ah;
  logic             nrfd_oe, next_nrfd_oe;
  logic             ndac_oe, next_ndac_oe;
  logic             srq_oe;
  logic             remote, next_remote;
  logic             lockout, next_lockout;
  logic             listen, next_listen;
  logic             talk, next_talk;
  logic             spoll, next_spoll;
  logic             clear, next_clear;
  logic             trig, next_trig;
  logic             panel_off;
  logic             atn, ifc, ren, dav, eoi;
  logic [6:0]       cmd;
  logic             engaged;
  logic             ready;
  logic             take;
  logic             cmd_take;
  logic             push;
  logic             fifo_ready;
  gbc_pkg::gbc_rx_t push_word;

  // Bus lines are low true; only seven bits carry command meaning.
  always_comb begin
    atn = !atn_n_in;
    ifc = !ifc_n_in;
    ren = !ren_n_in;
    dav = !dav_n_in;
    eoi = !eoi_n_in;
    cmd = ~dio_n_in[6:0];
    push_word.data = ~dio_n_in;
    push_word.eoi  = eoi;
  end

  // Acceptor: a byte is taken when idle, valid and engaged; only data bytes also need room.
  always_comb begin
    engaged  = atn || listen;
    ready    = atn || fifo_ready;
    take     = ah == AH_IDLE && dav && engaged && ready;
    cmd_take = take && atn;
    push     = take && !atn && listen;
    next_ah  = ah;
    case (ah)
      AH_IDLE: begin
        if (take) begin
          next_ah = AH_HOLD;
        end
      end
      AH_HOLD: begin
        if (!dav) begin
          next_ah = AH_IDLE;
        end
      end
      default: next_ah = AH_IDLE;
    endcase
    next_nrfd_oe = engaged && (next_ah == AH_HOLD || !ready);
    next_ndac_oe = engaged && next_ah == AH_IDLE;
  end

  // Acceptor state and line drivers.
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ah      <= AH_IDLE;
      nrfd_oe <= 1'b0;
      ndac_oe <= 1'b0;
      srq_oe  <= 1'b0;
    end else begin
      ah      <= next_ah;
      nrfd_oe <= next_nrfd_oe;
      ndac_oe <= next_ndac_oe;
      srq_oe  <= srq_cond_in;
    end
  end

  // Command interpreter for bytes taken under attention.
  always_comb begin
    next_remote  = remote;
    next_lockout = lockout;
    next_listen  = listen;
    next_talk    = talk;
    next_spoll   = spoll;
    next_clear   = 1'b0;
    next_trig    = 1'b0;
    if (cmd_take) begin
      case (cmd[6:5])
        gbc_pkg::GRP_UCG: begin
          case (cmd)
            gbc_pkg::CMD_LLO: next_lockout = 1'b1;
            gbc_pkg::CMD_DCL: next_clear = 1'b1;
            gbc_pkg::CMD_SPE: next_spoll = 1'b1;
            gbc_pkg::CMD_SPD: next_spoll = 1'b0;
            gbc_pkg::CMD_SDC: next_clear = listen;
            gbc_pkg::CMD_GTL: begin
              if (listen) begin
                next_remote = 1'b0;
                if (gtl_unlock_in) begin
                  next_lockout = 1'b0;
                end
              end
            end
            gbc_pkg::CMD_GET: next_trig = listen || trig_unaddr_in;
            default: next_clear = 1'b0;
          endcase
        end
        gbc_pkg::GRP_LAG: begin
          if (cmd == gbc_pkg::CMD_UNL) begin
            next_listen = 1'b0;
          end else if (addr_hit(cmd, gbc_pkg::GRP_LAG, my_addr_in)) begin
            next_listen = 1'b1;
            next_talk   = 1'b0;
            if (ren) begin
              next_remote = 1'b1;
            end
          end
        end
        gbc_pkg::GRP_TAG: begin
          if (cmd == gbc_pkg::CMD_UNT) begin
            next_talk = 1'b0;
          end else if (addr_hit(cmd, gbc_pkg::GRP_TAG, my_addr_in)) begin
            next_talk   = 1'b1;
            next_listen = 1'b0;
          end else begin
            next_talk = 1'b0;
          end
        end
        default: next_talk = talk;
      endcase
    end
    if (!ren) begin
      next_remote  = 1'b0;
      next_lockout = 1'b0;
    end
    if (ifc) begin
      next_listen = 1'b0;
      next_talk   = 1'b0;
    end
  end

  // Interface state registers.
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      remote    <= 1'b0;
      lockout   <= 1'b0;
      listen    <= 1'b0;
      talk      <= 1'b0;
      spoll     <= 1'b0;
      clear     <= 1'b0;
      trig      <= 1'b0;
      panel_off <= 1'b0;
    end else begin
      remote    <= next_remote;
      lockout   <= next_lockout;
      listen    <= next_listen;
      talk      <= next_talk;
      spoll     <= next_spoll;
      clear     <= next_clear;
      trig      <= next_trig;
      panel_off <= (next_remote && ren_panel_lock_in) || next_lockout;
    end
  end

  // Receive buffer; its fullness holds the bus off through NRFD.
  gbc_fifo #(
    .WIDTH ($bits(gbc_pkg::gbc_rx_t)),
    .DEPTH (gbc_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_in        (clk_in),
    .arst_n_in     (arst_n_in),
    .in_valid_in   (push),
    .in_ready_out  (fifo_ready),
    .in_data_in    (push_word),
    .out_valid_out (rx_valid_out),
    .out_ready_in  (rx_ready_in),
    .out_data_out  (rx_data_out)
  );

  // Open-drain lines only ever pull low.
  assign nrfd_n_out    = 1'b0;
  assign ndac_n_out    = 1'b0;
  assign srq_n_out     = 1'b0;
  assign nrfd_oe_out   = nrfd_oe;
  assign ndac_oe_out   = ndac_oe;
  assign srq_oe_out    = srq_oe;
  assign remote_out    = remote;
  assign lockout_out   = lockout;
  assign panel_off_out = panel_off;
  assign listen_out    = listen;
  assign talk_out      = talk;
  assign spoll_out     = spoll;
  assign clear_out     = clear;
  assign trigger_out   = trig;

  // Checks on the decoder and acceptor.
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);

  sequence s_byte_held;
    !ndac_oe && nrfd_oe;
  endsequence
  sequence s_byte_done;
    ndac_oe [*1];
  endsequence

  a_ifc_idle: assert property (ifc |=> !listen && !talk)
    else $error("IFC did not idle listener and talker");
  a_llo_lock: assert property (cmd_take && cmd == gbc_pkg::CMD_LLO && ren
    |=> lockout)
    else $error("LLO did not set lockout");
  a_dcl_clear: assert property (cmd_take && cmd == gbc_pkg::CMD_DCL
    |=> clear ##1 !clear)
    else $error("DCL clear pulse wrong");
  a_spe_spd: assert property (cmd_take && (cmd == gbc_pkg::CMD_SPE
    || cmd == gbc_pkg::CMD_SPD) |=> spoll == ($past(cmd)
    == gbc_pkg::CMD_SPE))
    else $error("Serial poll mode did not follow SPE or SPD");
  a_sdc_addressed: assert property (cmd_take && cmd == gbc_pkg::CMD_SDC
    |=> clear == $past(listen))
    else $error("SDC clear does not follow addressing");
  a_lag_listen: assert property (cmd_take && !ifc
    && addr_hit(cmd, gbc_pkg::GRP_LAG, my_addr_in)
    && cmd != gbc_pkg::CMD_UNL |=> listen && !talk)
    else $error("Own listen address not taken");
  a_tag_talk: assert property (cmd_take && !ifc
    && addr_hit(cmd, gbc_pkg::GRP_TAG, my_addr_in)
    && cmd != gbc_pkg::CMD_UNT |=> talk && !listen)
    else $error("Own talk address not taken");
  a_unl_idle: assert property (cmd_take && cmd == gbc_pkg::CMD_UNL
    |=> !listen)
    else $error("Unlisten did not idle the listener");
  a_unt_idle: assert property (cmd_take && cmd == gbc_pkg::CMD_UNT
    |=> !talk)
    else $error("Untalk did not idle the talker");
  a_scg_ignored: assert property (cmd_take && !ifc
    && cmd[6:5] == gbc_pkg::GRP_SCG
    |=> $stable(listen) && $stable(talk))
    else $error("Secondary code changed addressing");
  a_data_path: assert property (push |=> rx_valid_out && !ndac_oe)
    else $error("Data byte not stored");
  a_cmd_no_data: assert property (cmd_take && !rx_valid_out
    |=> !rx_valid_out)
    else $error("Command byte entered the data stream");
  a_accept_hold: assert property (take && listen && !atn
    |=> s_byte_held ##0 rx_valid_out)
    else $error("NDAC released before byte was stored");
  a_accept_end: assert property (ah == AH_HOLD && !dav && engaged
    |=> s_byte_done)
    else $error("NDAC not reasserted after DAV release");
  a_srq_follow: assert property (srq_cond_in [*2] |-> srq_oe)
    else $error("Service request not held");
  a_gtl_local: assert property (cmd_take && cmd == gbc_pkg::CMD_GTL
    && listen |=> !remote)
    else $error("GTL did not return to local");
endmodule

`default_nettype wire

// ### dv/gbc_ctrl_model.sv
// Behavioural bus controller that sources bytes to the decoder.
// Assumes the bench calls send_byte; released lines float high.
`timescale 1ns/1ps
`default_nettype none
module gbc_ctrl_model (
  // Clock.
  input  wire logic       clk_in,
  // Acceptor enables seen on the open-drain lines.
  input  wire logic       nrfd_oe_in,
  input  wire logic       ndac_oe_in,
  // Controller lines, low true.
  output var  logic [7:0] dio_n_out,
  output var  logic       atn_n_out,
  output var  logic       eoi_n_out,
  output var  logic       dav_n_out
);
  // All lines start released to the terminator level.
  initial begin
    dio_n_out = 8'hFF;
    atn_n_out = 1'b1;
    eoi_n_out = 1'b1;
    dav_n_out = 1'b1;
  end
  // One source handshake; ok stays low if the device never answers.
  task automatic send_byte(input logic [7:0] val, input logic atn,
                           input logic eoi, output logic ok);
    int n;
    ok = 1'b0;
    @(negedge clk_in);
    atn_n_out = ~atn;
    dio_n_out = ~val;
    eoi_n_out = ~eoi;
    for (n = 0; n < 40 && !ok; n++) begin
      @(negedge clk_in);
      ok = !nrfd_oe_in;
    end
    // Data valid only once every acceptor is ready.
    if (ok) begin
      dav_n_out = 1'b0;
      ok = 1'b0;
      for (n = 0; n < 40 && !ok; n++) begin
        @(negedge clk_in);
        ok = !ndac_oe_in;
      end
    end
    dav_n_out = 1'b1;
    dio_n_out = 8'hFF;
    eoi_n_out = 1'b1;
    repeat (2) @(negedge clk_in);
  endtask
endmodule
`default_nettype wire

// ### dv/test_gbc_decoder.sv
// Self-checking bench for the bus command decoder.
// Assumes the controller model sources every bus byte.
`timescale 1ns/1ps
`default_nettype none
module test_gbc_decoder;
  logic             clk_in, arst_n_in, ifc_n_in, ren_n_in, ok;
  logic             srq_cond_in, trig_unaddr_in, rx_ready_in;
  logic             gtl_unlock, panel_lock;
  logic [4:0]       my_addr_in;
  logic [7:0]       dio_n, v;
  logic             atn_n, eoi_n, dav_n, nrfd_oe, ndac_oe, srq_oe_out;
  logic             remote_out, lockout_out, panel_off_out, listen_out;
  logic             talk_out, spoll_out, clear_out, trigger_out;
  logic             rx_valid_out;
  gbc_pkg::gbc_rx_t rx_data_out;
  logic [10:0]      expq[$];
  int               mismatches, compares, n;
  string            txt = "*RST";
  // Free-running 200 MHz clock.
  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end
  // Design under test and its bus controller.
  gbc_decoder gbc_decoder_inst (
    .clk_in(clk_in), .arst_n_in(arst_n_in), .dio_n_in(dio_n),
    .atn_n_in(atn_n), .ifc_n_in(ifc_n_in), .ren_n_in(ren_n_in),
    .eoi_n_in(eoi_n), .dav_n_in(dav_n), .nrfd_n_out(), .ndac_n_out(),
    .srq_n_out(), .nrfd_oe_out(nrfd_oe), .ndac_oe_out(ndac_oe),
    .srq_oe_out(srq_oe_out), .my_addr_in(my_addr_in),
    .trig_unaddr_in(trig_unaddr_in), .gtl_unlock_in(gtl_unlock),
    .ren_panel_lock_in(panel_lock), .srq_cond_in(srq_cond_in),
    .remote_out(remote_out), .lockout_out(lockout_out),
    .panel_off_out(panel_off_out), .listen_out(listen_out),
    .talk_out(talk_out), .spoll_out(spoll_out), .clear_out(clear_out),
    .trigger_out(trigger_out), .rx_valid_out(rx_valid_out),
    .rx_ready_in(rx_ready_in), .rx_data_out(rx_data_out));
  gbc_ctrl_model gbc_ctrl_model_inst (
    .clk_in(clk_in), .nrfd_oe_in(nrfd_oe), .ndac_oe_in(ndac_oe),
    .dio_n_out(dio_n), .atn_n_out(atn_n), .eoi_n_out(eoi_n),
    .dav_n_out(dav_n));
  // Compare helpers, bus helpers and the closing report.
  task automatic chk(input string what, input logic [10:0] e,
                     input logic [10:0] g);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", what, e, g);
    end
  endtask
  task automatic bus(input logic [7:0] b, input logic atn,
                     input logic eoi);
    gbc_ctrl_model_inst.send_byte(b, atn, eoi, ok);
    chk("handshake", 11'h1, {10'h0, ok});
  endtask
  task automatic cmd(input logic [6:0] c);
    bus({1'($urandom), c}, 1'b1, 1'b0);
  endtask
  task automatic st(input logic [5:0] e);
    chk("state", {5'h0, e}, {5'h0, remote_out, lockout_out,
        panel_off_out, listen_out, talk_out, spoll_out});
  endtask
  task automatic ifc_pulse(input logic [6:0] c);
    cmd(c);
    ifc_n_in = 1'b0;
    @(negedge clk_in);
    ifc_n_in = 1'b1;
    @(negedge clk_in);
    st(6'h00);
  endtask
  task automatic take(input logic [10:0] g);
    logic [10:0] e;
    e = (expq.size() > 0) ? expq.pop_front() : 11'h7FF;
    chk("result", e, g);
  endtask
  task automatic complete_run;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Takes the oldest note for each pulse or word that leaves the design.
  always @(posedge clk_in) begin
    if (arst_n_in) begin
      if (clear_out === 1'b1) take(11'h200);
      if (trigger_out === 1'b1) take(11'h400);
      if (rx_valid_out === 1'b1 && rx_ready_in === 1'b1)
        take({2'h0, rx_data_out});
    end
  end
  // Main sequence.
  initial begin
    void'($urandom(32'h59DC));
    {arst_n_in, ifc_n_in, ren_n_in} = 3'h3;
    {srq_cond_in, trig_unaddr_in, rx_ready_in} = 3'h0;
    {gtl_unlock, panel_lock} = 2'h3;
    my_addr_in = 5'h10;
    repeat (5) @(negedge clk_in);
    arst_n_in = 1'b1;
    repeat (2) @(negedge clk_in);
    st(6'h00);
    ren_n_in = 1'b0;
    cmd(7'h3F);
    cmd(7'h30);
    st(6'h2C);
    cmd(7'h50);
    st(6'h2A);
    cmd(7'h5F);
    st(6'h28);
    cmd(7'h50);
    cmd(7'h45);
    st(6'h28);
    cmd(7'h30);
    repeat (4) cmd(7'h60 | 7'($urandom_range(31)));
    st(6'h2C);
    cmd(7'h3F);
    st(6'h28);
    my_addr_in = 5'h1F;
    cmd(7'h3F);
    st(6'h28);
    my_addr_in = 5'h10;
    $display("addressing done");
    cmd(7'h04);
    cmd(7'h08);
    trig_unaddr_in = 1'b1;
    expq.push_back(11'h400);
    cmd(7'h08);
    trig_unaddr_in = 1'b0;
    cmd(7'h30);
    expq.push_back(11'h200);
    cmd(7'h04);
    expq.push_back(11'h400);
    cmd(7'h08);
    $display("addressed commands done");
    cmd(7'h3F);
    cmd(7'h11);
    st(6'h38);
    cmd(7'h18);
    st(6'h39);
    cmd(7'h19);
    st(6'h38);
    expq.push_back(11'h200);
    cmd(7'h14);
    cmd(7'h01);
    st(6'h38);
    {gtl_unlock, panel_lock} = 2'h0;
    cmd(7'h30);
    cmd(7'h01);
    st(6'h1C);
    gtl_unlock = 1'b1;
    cmd(7'h30);
    cmd(7'h01);
    st(6'h04);
    cmd(7'h30);
    st(6'h24);
    panel_lock = 1'b1;
    ren_n_in = 1'b1;
    cmd(7'h30);
    st(6'h04);
    $display("universal commands done");
    rx_ready_in = 1'b1;
    for (n = 0; n < 4; n++) begin
      expq.push_back({2'h0, txt[n], n == 3});
      bus(txt[n], 1'b0, n == 3);
    end
    cmd(7'h3F);
    bus(8'h55, 1'b0, 1'b0);
    cmd(7'h30);
    rx_ready_in = 1'b0;
    for (n = 0; n < 16; n++) begin
      v = 8'($urandom);
      expq.push_back({2'h0, v, 1'b0});
      bus(v, 1'b0, 1'b0);
    end
    gbc_ctrl_model_inst.send_byte(8'hA5, 1'b0, 1'b0, ok);
    chk("refusal", 11'h0, {10'h0, ok});
    for (n = 0; n < 300 && expq.size() > 0; n++) begin
      @(negedge clk_in);
      rx_ready_in = 1'($urandom);
    end
    @(negedge clk_in);
    rx_ready_in = 1'b1;
    chk("drained", 11'h0, {10'h0, rx_valid_out});
    $display("data stream done");
    ifc_pulse(7'h50);
    ifc_pulse(7'h30);
    srq_cond_in = 1'b1;
    repeat (6) @(negedge clk_in);
    chk("srq", 11'h1, {10'h0, srq_oe_out});
    srq_cond_in = 1'b0;
    repeat (2) @(negedge clk_in);
    chk("srq", 11'h0, {10'h0, srq_oe_out});
    cmd(7'h30);
    arst_n_in = 1'b0;
    repeat (2) @(negedge clk_in);
    st(6'h00);
    arst_n_in = 1'b1;
    $display("service and reset done");
    chk("pending", 11'h0, 11'(expq.size()));
    complete_run();
  end
endmodule
`default_nettype wire
